//--- hw/banked_data_memory.v
// banked ram data memory with direct and indirect address decoding
// Overview of operation
// - 128 bytes of 8-bit volatile general memory
// - general area 80h to ffh, bank 0, read/write
// - special registers bankless; eeprom control 40h bank 1 only
// - space starts at 00h; bank changes on write only
// - indirect port access goes to pointed location
// - port zero bank 0; port one selected bank
// - indirect access to port address: read 00h, no write
// - pointers are real read/write registers
// - direct access always bank 0
// - bank select bit 0 picks bank for port one
// - reset clears bank, except watchdog wake in power down
// - unused special locations read 00h
// - protected special registers refuse program writes
`timescale 1ns/1ns
`include "banked_mem_regs.vh"
module banked_data_memory (
  input wire ref_clk_i,
  input wire rst_i,
  input wire wdt_pd_reset_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output reg [7:0] sfr_addr_o,
  output reg sfr_rd_o,
  output reg sfr_wr_o,
  output reg [7:0] sfr_wdata_o,
  input wire [7:0] sfr_rdata_i,
  input wire sfr_present_i,
  input wire sfr_protected_i,
  output reg eeprom_control_rd_o,
  output reg eeprom_control_wr_o,
  input wire [7:0] eeprom_control_rdata_i,
  output reg bank_o
);

  reg [7:0] gp_mem [0:`GP_DEPTH-1];
  reg [7:0] pointer_zero_q;
  reg [7:0] pointer_one_q;
  reg bank_q;
  reg [7:0] eff_addr;
  reg eff_bank;
  reg port_self;
  reg is_gp;
  reg is_eec;
  reg is_sfr;
  reg [7:0] rd_mux;
  wire is_port0;
  wire is_port1;

  assign is_port0 = (addr_i == `ADDR_INDIRECT_PORT_ZERO);
  assign is_port1 = (addr_i == `ADDR_INDIRECT_PORT_ONE);

  // effective address and bank resolution
  always @* begin
    eff_addr = addr_i;
    eff_bank = 1'b0;
    port_self = 1'b0;
    if (is_port0) begin
      eff_addr = pointer_zero_q;
      eff_bank = 1'b0;
      port_self = 1'b1;
    end else if (is_port1) begin
      eff_addr = pointer_one_q;
      eff_bank = bank_q;
      port_self = 1'b1;
    end
    // pointer aimed at a port address itself
    if (port_self) begin
      port_self = (eff_addr == `ADDR_INDIRECT_PORT_ZERO) || (eff_addr == `ADDR_INDIRECT_PORT_ONE);
    end
    is_gp = eff_addr[7] && !eff_bank;
    is_eec = eff_bank && (eff_addr == `ADDR_EEPROM_CONTROL);
    is_sfr = !eff_addr[7] && !is_eec && !(eff_addr == `ADDR_EEPROM_CONTROL) && !port_self;
    rd_mux = `READ_ZERO;
    if (port_self) begin
      rd_mux = `READ_ZERO;
    end else if (is_gp) begin
      rd_mux = gp_mem[eff_addr[6:0]];
    end else if (is_eec) begin
      rd_mux = eeprom_control_rdata_i;
    end else if (eff_addr == `ADDR_POINTER_ZERO) begin
      rd_mux = pointer_zero_q;
    end else if (eff_addr == `ADDR_POINTER_ONE) begin
      rd_mux = pointer_one_q;
    end else if (eff_addr == `ADDR_BANK_SELECT) begin
      rd_mux = {7'h00, bank_q};
    end else if (is_sfr && sfr_present_i) begin
      rd_mux = sfr_rdata_i;
    end else begin
      rd_mux = `READ_ZERO;
    end
  end

  // general purpose array, bank 0 only
  always @(posedge ref_clk_i) begin
    if (wr_i && is_gp && !port_self) begin
      gp_mem[eff_addr[6:0]] <= wdata_i;
    end
  end

  // core registers, bank select and outputs
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pointer_zero_q <= `POINTER_RESET;
      pointer_one_q <= `POINTER_RESET;
      if (!wdt_pd_reset_i) begin
        bank_q <= `BANK_SELECT_RESET;
      end
      rdata_o <= `READ_ZERO;
      rvalid_o <= 1'b0;
      sfr_addr_o <= 8'h00;
      sfr_rd_o <= 1'b0;
      sfr_wr_o <= 1'b0;
      sfr_wdata_o <= 8'h00;
      eeprom_control_rd_o <= 1'b0;
      eeprom_control_wr_o <= 1'b0;
      // a watchdog wake in power down keeps the bank, so the mirror keeps it too
      if (!wdt_pd_reset_i) begin
        bank_o <= `BANK_SELECT_RESET;
      end
    end else begin
      if (wr_i && !port_self && !eff_addr[7]) begin
        if (eff_addr == `ADDR_POINTER_ZERO) begin
          pointer_zero_q <= wdata_i;
        end
        if (eff_addr == `ADDR_POINTER_ONE) begin
          pointer_one_q <= wdata_i;
        end
        if (eff_addr == `ADDR_BANK_SELECT) begin
          bank_q <= wdata_i[`BANK_SELECT_BIT];
        end
      end
      rdata_o <= rd_i ? rd_mux : `READ_ZERO;
      rvalid_o <= rd_i;
      sfr_addr_o <= eff_addr;
      sfr_rd_o <= rd_i && is_sfr && eff_addr > `ADDR_BANK_SELECT;
      sfr_wr_o <= wr_i && is_sfr && eff_addr > `ADDR_BANK_SELECT && !sfr_protected_i;
      sfr_wdata_o <= wdata_i;
      eeprom_control_rd_o <= rd_i && is_eec && !port_self;
      eeprom_control_wr_o <= wr_i && is_eec && !port_self;
      bank_o <= (wr_i && !port_self && eff_addr == `ADDR_BANK_SELECT) ? wdata_i[`BANK_SELECT_BIT] : bank_q;
    end
  end

endmodule // banked_data_memory

//--- hw/banked_mem_regs.vh
// register offsets, field positions and reset values of the banked data memory
`ifndef BANKED_MEM_REGS_VH
`define BANKED_MEM_REGS_VH
`define ADDR_INDIRECT_PORT_ZERO 8'h00
`define ADDR_POINTER_ZERO 8'h01
`define ADDR_INDIRECT_PORT_ONE 8'h02
`define ADDR_POINTER_ONE 8'h03
`define ADDR_BANK_SELECT 8'h04
`define ADDR_EEPROM_CONTROL 8'h40
`define ADDR_GP_BASE 8'h80
`define BANK_SELECT_BIT 0
`define BANK_SELECT_RESET 1'b0
`define POINTER_RESET 8'h00
`define READ_ZERO 8'h00
`define GP_DEPTH 128
`define SFR_BANK1_VALUE 8'h01
`endif

//--- testbench/banked_data_memory_assertions.sv
// checker of the banked data memory port behaviour
`timescale 1ns/1ns
module banked_data_memory_assertions (
  input wire ref_clk_i, rst_i, wdt_pd_reset_i, rd_i, wr_i, rvalid_o, bank_o,
  input wire [7:0] addr_i, wdata_i, rdata_o,
  input wire sfr_wr_o, sfr_protected_i, eeprom_control_rd_o, eeprom_control_wr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_ans; rd_i |=> rvalid_o; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_idle; !rvalid_o |-> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_bank_rd; rd_i && addr_i == 8'h04 |=> rdata_o == {7'h00, bank_o}; endproperty
  a_bank_rd: assert property (p_bank_rd) else $error("bank read wrong");
  property p_bank_wr; wr_i && addr_i == 8'h04 |=> bank_o == $past(wdata_i[0]); endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("bank write lost");
  property p_hold; !(wr_i && addr_i == 8'h04) |=> $stable(bank_o); endproperty
  a_hold: assert property (p_hold) else $error("bank changed without write");
  property p_dir; rd_i && addr_i != 8'h02 |=> !eeprom_control_rd_o; endproperty
  a_dir: assert property (p_dir) else $error("eeprom control reached directly");
  property p_eec; eeprom_control_rd_o || eeprom_control_wr_o |-> bank_o; endproperty
  a_eec: assert property (p_eec) else $error("eeprom control outside bank 1");
  property p_prot; sfr_wr_o |-> !$past(sfr_protected_i); endproperty
  a_prot: assert property (p_prot) else $error("protected register written");
  property p_rst; disable iff (1'b0) rst_i && !wdt_pd_reset_i |=> !bank_o; endproperty
  a_rst: assert property (p_rst) else $error("bank not cleared by reset");
endmodule // banked_data_memory_assertions

//--- testbench/sfr_model.sv
// peripheral register side: fixed read values, all present, none protected
`timescale 1ns/1ns
module sfr_model (
  output wire [7:0] rdata_o,
  output wire present_o,
  output wire protected_o,
  output wire [7:0] eeprom_rdata_o
);
  assign rdata_o = 8'h5a;
  assign present_o = 1'b1;
  assign protected_o = 1'b0;
  assign eeprom_rdata_o = 8'hc3;
endmodule // sfr_model

//--- testbench/banked_data_memory_tb.sv
// self-checking bench of the banked data memory
`timescale 1ns/1ns
module banked_data_memory_tb;
  reg ref_clk_i = 0, rst_i = 1, wdt_pd_reset_i = 0, rd_i = 0, wr_i = 0;
  reg [7:0] addr_i = 8'h00, wdata_i = 8'h00, a;
  reg [15:0] r = 16'h974e;
  integer err_count = 0, checked = 0, k;
  wire [7:0] rdata_o, sfr_rdata_i, eeprom_control_rdata_i, sfr_addr_o, sfr_wdata_o;
  wire rvalid_o, bank_o, sfr_present_i, sfr_protected_i, sfr_rd_o, sfr_wr_o;
  wire eeprom_control_rd_o, eeprom_control_wr_o;
  banked_data_memory banked_data_memory_i (.*);
  sfr_model sfr_model_i (.rdata_o(sfr_rdata_i), .present_o(sfr_present_i), .protected_o(sfr_protected_i),
    .eeprom_rdata_o(eeprom_control_rdata_i));
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  function [15:0] lf(input [15:0] s);
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task ck(input string n, input [7:0] s, input [7:0] e);
    checked = checked + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] ad, input [7:0] d);
    @(negedge ref_clk_i); wr_i = 1; addr_i = ad; wdata_i = d;
    @(negedge ref_clk_i); wr_i = 0;
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    @(negedge ref_clk_i); rd_i = 1; addr_i = ad;
    @(negedge ref_clk_i); rd_i = 0;
    ck("rvalid", {7'h00, rvalid_o}, 8'h01);
    ck("rdata", rdata_o, e);
  endtask
  task rs(input w);
    wdt_pd_reset_i = w; rst_i = 1;
    repeat (4) @(negedge ref_clk_i);
    rst_i = 0; wdt_pd_reset_i = 0;
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    rs(0);
    ck("bank", bank_o, 8'h00);
    rd(8'h01, 8'h00);
    for (k = 0; k < 6; k = k + 1) begin
      r = lf(r); a = {1'b1, r[6:0]}; wr(a, r[15:8]);
      rd(a, r[15:8]);
    end
    wr(8'h01, 8'h85); wr(8'h00, 8'h3c);
    rd(8'h85, 8'h3c);
    rd(8'h01, 8'h85);
    wr(8'h01, 8'h02);
    rd(8'h00, 8'h00);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h5a);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h01);
    wr(8'h03, 8'h40);
    rd(8'h02, 8'hc3);
    rd(8'h40, 8'h00);
    rd(8'h85, 8'h3c);
    wr(8'h03, 8'h85);
    rd(8'h02, 8'h00);
    rs(1);
    ck("bank", bank_o, 8'h01);
    rs(0);
    ck("bank", bank_o, 8'h00);
    wr(8'h03, 8'h85);
    rd(8'h02, 8'h3c);
    tally_and_finish;
  end
endmodule // banked_data_memory_tb
bind banked_data_memory banked_data_memory_assertions banked_data_memory_assertions_i (.*);
